//--- core/spf_pkg.sv
/*
 * Shared constants for the self-programming flash control block:
 * register map, control field layout, operation encodings and windows.
 * Assumes an AXI4-Lite master and a core that pulses store/load strobes.
 */
package spf_pkg;
	// ==========================================================
	// Register map
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_LOCK = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Control field positions
	localparam int CS_IE = 7;
	localparam int CS_BUSY = 6;
	localparam int CS_SIG = 5;
	localparam int CS_REEN = 4;
	localparam int CS_ARM = 0;
	localparam logic [4:0] PAT_FILL = 5'h01;
	localparam logic [4:0] PAT_ERASE = 5'h03;
	localparam logic [4:0] PAT_WRITE = 5'h05;
	localparam logic [4:0] PAT_LOCK = 5'h09;
	localparam logic [4:0] PAT_REEN = 5'h11;
	// ==========================================================
	// Lock byte layout
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [7:0] BOOT_MASK = 8'h3c;
	localparam int BOOT_HI = 5;
	localparam int BOOT_LO = 4;
	localparam int APP_HI = 3;
	localparam int APP_LO = 2;
	localparam int MEM_HI = 1;
	localparam int MEM_LO = 0;
	// ==========================================================
	// Pointer fields and windows
	localparam int Z_WORD_LSB = 1;
	localparam int Z_PAGE_LSB = 8;
	localparam logic [2:0] WIN_STORE = 3'h4;
	localparam logic [2:0] LOAD_FLOOR = 3'h2;
	typedef enum logic [2:0] {
		MODE_NONE = 3'b000,
		MODE_FILL = 3'b001,
		MODE_ERASE = 3'b010,
		MODE_WRITE = 3'b011,
		MODE_LOCK = 3'b100,
		MODE_REEN = 3'b101,
		MODE_SIG = 3'b110
	} spf_mode_t;
endpackage : spf_pkg

//--- core/spf_ctrl.sv
/*
 * Self-programming flash control: control/status register over AXI4-Lite,
 * arm windows, page buffer, lock bits and section protection.
 * Assumes the flash array pulses flash_done_i when an erase or write ends.
 */
`timescale 1ns/1ns
module spf_ctrl #(
	parameter int Z_W = 18,
	parameter logic [Z_W-spf_pkg::Z_PAGE_LSB-1:0] STALLING_SECTION_PG = 'd992,
	parameter logic [Z_W-spf_pkg::Z_PAGE_LSB-1:0] BOOT_PG = 'd992
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [spf_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [spf_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic store_instr_i,
	input wire logic load_instr_i,
	input wire logic [Z_W-1:0] zptr_i,
	input wire logic [15:0] data_pair_i,
	input wire logic exec_boot_i,
	input wire logic vec_boot_i,
	input wire logic global_int_i,
	input wire logic [7:0] fuse_byte_i,
	input wire logic [7:0] sig_byte_i,
	input wire logic chip_erase_i,
	input wire logic ext_lock_wr_i,
	input wire logic [7:0] ext_lock_data_i,
	input wire logic flash_done_i,
	input wire logic [spf_pkg::Z_PAGE_LSB-spf_pkg::Z_WORD_LSB-1:0] buf_rd_idx_i,
	output logic [15:0] buf_rd_data_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [Z_W-spf_pkg::Z_PAGE_LSB-1:0] flash_page_o,
	output logic [7:0] load_data_o,
	output logic load_valid_o,
	output logic access_refused_o,
	output logic core_stall_o,
	output logic section_busy_o,
	output logic ready_irq_o,
	output logic int_block_o,
	output logic ext_prog_block_o,
	output logic verify_block_o,
	output logic fuse_locked_o,
	output logic boot_lock_locked_o
);
	import spf_pkg::*;
	localparam int WI_W = Z_PAGE_LSB - Z_WORD_LSB;
	localparam int WORDS = 2 ** WI_W;

	// ==========================================================
	// Register bus
	logic aw_full_q, w_full_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic wr_fire, cw, reg_hit;
	logic ie_q;
	logic [7:0] ctrl_rd, rd_mux;

	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
	assign reg_hit = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_LOCK);
	assign cw = wr_fire && (awaddr_q == OFF_CTRL) && wstrb0_q;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata_i[7:0];
				wstrb0_q <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= reg_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= {24'h0, rd_mux};
				s_axi_rresp_o <= (s_axi_araddr_i == OFF_CTRL || s_axi_araddr_i == OFF_LOCK) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Command decode and arm window
	spf_mode_t mode_q, wr_mode;
	logic [2:0] win_q;
	logic busy_q, arm, st, ld, ld_special, go, refuse_op;
	logic is_rww, is_boot, wr_locked, rd_locked;
	logic tgt_rww_q, section_busy_flag_q;
	logic [7:0] lock_q;
	logic [Z_W-Z_PAGE_LSB-1:0] pg;
	logic [WI_W-1:0] widx;

	assign pg = zptr_i[Z_W-1:Z_PAGE_LSB];
	assign widx = zptr_i[Z_PAGE_LSB-1:Z_WORD_LSB];
	assign is_rww = pg < STALLING_SECTION_PG;
	assign is_boot = pg >= BOOT_PG;
	// Store protection keys off the low lock bit of the boot or application pair
	assign wr_locked = is_boot ? !lock_q[BOOT_LO] : !lock_q[APP_LO];
	assign rd_locked = is_boot ? (!exec_boot_i && !lock_q[BOOT_HI]) :
		(exec_boot_i && !lock_q[APP_HI]);
	assign arm = (win_q != 3'h0) || busy_q;
	assign st = store_instr_i && (win_q != 3'h0) && !busy_q;
	assign ld = load_instr_i;
	assign ld_special = ld && (win_q >= LOAD_FLOOR) &&
		(mode_q == MODE_SIG || mode_q == MODE_LOCK);
	// Page write needs word index zero; a stray index would mis-target the page
	assign refuse_op = wr_locked || (mode_q == MODE_WRITE && widx != '0);
	assign go = st && (mode_q == MODE_ERASE || mode_q == MODE_WRITE) && !refuse_op;
	assign ctrl_rd = {ie_q, section_busy_flag_q, mode_q == MODE_SIG, mode_q == MODE_REEN, mode_q == MODE_LOCK,
		mode_q == MODE_WRITE, mode_q == MODE_ERASE, arm};
	assign rd_mux = (s_axi_araddr_i == OFF_CTRL) ? ctrl_rd :
		(s_axi_araddr_i == OFF_LOCK) ? lock_q : 8'h00;

	always_comb begin
		wr_mode = MODE_NONE;
		if (wdata_q[CS_SIG]) begin
			if (wdata_q[4:0] == PAT_FILL) begin
				wr_mode = MODE_SIG;
			end
		end else begin
			case (wdata_q[4:0])
				PAT_FILL: wr_mode = MODE_FILL;
				PAT_ERASE: wr_mode = MODE_ERASE;
				PAT_WRITE: wr_mode = MODE_WRITE;
				PAT_LOCK: wr_mode = MODE_LOCK;
				PAT_REEN: wr_mode = MODE_REEN;
				default: wr_mode = MODE_NONE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ie_q <= 1'b0;
		end else if (ce_i && cw) begin
			ie_q <= wdata_q[CS_IE];
		end
	end

	// Arming is ignored while an erase or write is running
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			mode_q <= MODE_NONE;
			win_q <= 3'h0;
			busy_q <= 1'b0;
		end else if (ce_i) begin
			if (busy_q) begin
				if (flash_done_i) begin
					busy_q <= 1'b0;
					mode_q <= MODE_NONE;
				end
			end else if (st) begin
				win_q <= 3'h0;
				busy_q <= go;
				if (!go) begin
					mode_q <= MODE_NONE;
				end
			end else if (cw && wr_mode != MODE_NONE) begin
				mode_q <= wr_mode;
				win_q <= WIN_STORE;
			end else if (win_q != 3'h0) begin
				win_q <= win_q - 3'h1;
				if (win_q == 3'h1) begin
					mode_q <= MODE_NONE;
				end
			end
		end
	end

	// ==========================================================
	// Flash operation start, busy flag and stall
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			flash_erase_o <= 1'b0;
			flash_write_o <= 1'b0;
			flash_page_o <= '0;
			tgt_rww_q <= 1'b0;
			core_stall_o <= 1'b0;
		end else if (ce_i) begin
			flash_erase_o <= go && mode_q == MODE_ERASE;
			flash_write_o <= go && mode_q == MODE_WRITE;
			if (go) begin
				flash_page_o <= pg;
				tgt_rww_q <= is_rww;
				core_stall_o <= !is_rww;
			end else if (busy_q && flash_done_i) begin
				core_stall_o <= 1'b0;
			end
		end
	end

	// Set beats clear: a new start below STALLING_SECTION_PG always leaves the flag raised
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			section_busy_flag_q <= 1'b0;
		end else if (ce_i) begin
			if (go && is_rww) begin
				section_busy_flag_q <= 1'b1;
			end else if (st && (mode_q == MODE_REEN || mode_q == MODE_FILL)) begin
				section_busy_flag_q <= 1'b0;
			end
		end
	end
	assign section_busy_o = section_busy_flag_q;

	// ==========================================================
	// Page buffer
	logic [15:0] buf_q [WORDS];
	logic [WORDS-1:0] wv_q;
	logic fill_st, buf_drop;

	assign fill_st = st && mode_q == MODE_FILL;
	assign buf_drop = (cw && wdata_q[CS_REEN] && (wv_q != '0)) ||
		(busy_q && flash_done_i && mode_q == MODE_WRITE);

	always_ff @(posedge clk_sys_i) begin
		if (ce_i && fill_st) begin
			buf_q[widx] <= data_pair_i;
		end
	end

	generate
		for (genvar i = 0; i < WORDS; i++) begin : g_wv
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					wv_q[i] <= 1'b0;
				end else if (ce_i) begin
					if (buf_drop) begin
						wv_q[i] <= 1'b0;
					end else if (fill_st && widx == WI_W'(i)) begin
						wv_q[i] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Discarded words read back as erased
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			buf_rd_data_o <= 16'hffff;
		end else if (ce_i) begin
			buf_rd_data_o <= wv_q[buf_rd_idx_i] ? buf_q[buf_rd_idx_i] : 16'hffff;
		end
	end

	// ==========================================================
	// Lock bits; programming only ever clears bits
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			lock_q <= LOCK_RST;
		end else if (ce_i) begin
			if (chip_erase_i) begin
				lock_q <= LOCK_RST;
			end else if (st && mode_q == MODE_LOCK) begin
				lock_q <= lock_q & (data_pair_i[7:0] | ~BOOT_MASK);
			end else if (ext_lock_wr_i) begin
				lock_q <= lock_q & (ext_lock_data_i | (lock_q[MEM_HI] ? 8'hc0 : 8'hfc));
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ext_prog_block_o <= 1'b0;
			verify_block_o <= 1'b0;
			fuse_locked_o <= 1'b0;
			boot_lock_locked_o <= 1'b0;
			int_block_o <= 1'b0;
			ready_irq_o <= 1'b0;
		end else if (ce_i) begin
			ext_prog_block_o <= !lock_q[MEM_LO] || !lock_q[MEM_HI];
			fuse_locked_o <= !lock_q[MEM_LO] || !lock_q[MEM_HI];
			verify_block_o <= !lock_q[MEM_HI];
			boot_lock_locked_o <= !lock_q[MEM_HI];
			int_block_o <= (vec_boot_i && !exec_boot_i && !lock_q[APP_HI]) ||
				(!vec_boot_i && exec_boot_i && !lock_q[BOOT_HI]);
			ready_irq_o <= ie_q && global_int_i && !arm;
		end
	end

	// ==========================================================
	// Load answers and refusals
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			load_valid_o <= 1'b0;
			load_data_o <= 8'h00;
			access_refused_o <= 1'b0;
		end else if (ce_i) begin
			load_valid_o <= ld_special;
			access_refused_o <= (st && (mode_q == MODE_ERASE || mode_q == MODE_WRITE) && refuse_op) ||
				(ld && !ld_special && ((section_busy_flag_q && is_rww) || rd_locked));
			if (ld_special) begin
				if (mode_q == MODE_SIG) begin
					load_data_o <= sig_byte_i;
				end else begin
					load_data_o <= zptr_i[0] ? fuse_byte_i : lock_q;
				end
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	property p_irq;
		(ce_i && ie_q && global_int_i && !arm) |=> ready_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("ready interrupt missing");

	property p_busy;
		(ce_i && go && is_rww) |=> section_busy_o && busy_q;
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag not set");

	property p_expire;
		(ce_i && win_q == 3'h1 && !st && !busy_q) |=> (mode_q == MODE_NONE || win_q == WIN_STORE);
	endproperty
	a_expire: assert property (p_expire) else $error("select bit kept after window");

	property p_lockmono;
		(ce_i && !chip_erase_i) |=> ((lock_q & ~$past(lock_q)) == 8'h00);
	endproperty
	a_lockmono: assert property (p_lockmono) else $error("lock bit returned to one");

	property p_sig;
		(ce_i && ld && mode_q == MODE_SIG && win_q >= LOAD_FLOOR) |=>
			(load_valid_o && load_data_o == $past(sig_byte_i));
	endproperty
	a_sig: assert property (p_sig) else $error("signature byte not returned");

	property p_stall;
		(ce_i && go && !is_rww) |=> core_stall_o ##1 (core_stall_o || $past(flash_done_i));
	endproperty
	a_stall: assert property (p_stall) else $error("core not stalled");

	property p_applock;
		(ce_i && st && mode_q == MODE_ERASE && !is_boot && !lock_q[APP_LO]) |=>
			(access_refused_o && !flash_erase_o);
	endproperty
	a_applock: assert property (p_applock) else $error("locked section erased");

	property p_abort;
		(ce_i && cw && wdata_q[CS_REEN] && !fill_st) |=> (wv_q == '0);
	endproperty
	a_abort: assert property (p_abort) else $error("buffer kept after re-enable");

	property p_window;
		(ce_i && cw && wr_mode != MODE_NONE && !busy_q && !st) |=> (win_q == WIN_STORE);
	endproperty
	a_window: assert property (p_window) else $error("arm window not opened");

	c_start: cover property (go ##[1:20] flash_done_i);
	c_sig: cover property (cw && wr_mode == MODE_SIG ##[1:3] load_valid_o);
	c_lock: cover property (st && mode_q == MODE_LOCK);
endmodule : spf_ctrl

//--- test/spf_core_model.sv
/*
 * Core-side partner: issues store and load program strobes with pointer and data.
 * Assumes its task is entered just after a rising edge of the system clock.
 */
`timescale 1ns/1ns
module spf_core_model (
	input wire logic clk_i,
	output logic store_o,
	output logic load_o,
	output logic [17:0] zptr_o,
	output logic [15:0] data_o
);
	// ==========================================================
	// Strobe driver
	initial begin
		store_o = 1'b0;
		load_o = 1'b0;
		zptr_o = 18'h0;
		data_o = 16'h0;
	end

	// Blocking task, so only one strobe is ever in flight
	task automatic op(input logic st, input logic [17:0] z, input logic [15:0] d);
		store_o <= st;
		load_o <= !st;
		zptr_o <= z;
		data_o <= d;
		@(posedge clk_i);
		store_o <= 1'b0;
		load_o <= 1'b0;
		// Released operands are inverted so stale values never pass as current
		zptr_o <= ~z;
		data_o <= ~d;
		#1;
	endtask : op
endmodule : spf_core_model

//--- test/tb.sv
/*
 * Self-checking bench for spf_ctrl: AXI4-Lite register tasks and core strobes.
 * Assumes the core partner model; flash completion is pulsed by the bench.
 */
`timescale 1ns/1ns
module tb;
	import spf_pkg::*;
	// Arbitrary byte values, chosen only to be recognisable
	localparam logic [7:0] FUSE_VAL = 8'h5a;
	localparam logic [7:0] SIG_VAL = 8'h96;
	logic clk_sys_i = 1'b0, srst_i = 1'b1;
	logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, resp;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic store_instr_i, load_instr_i;
	logic [17:0] zptr_i;
	logic [15:0] data_pair_i, buf_rd_data_o;
	logic exec_boot_i = 1'b0, vec_boot_i = 1'b0, global_int_i = 1'b1;
	logic chip_erase_i = 1'b0, ext_lock_wr_i = 1'b0, flash_done_i = 1'b0;
	logic [7:0] ext_lock_data_i = 8'hff, fuse_byte_i = FUSE_VAL, load_data_o;
	logic [6:0] buf_rd_idx_i = 7'h0;
	logic [9:0] flash_page_o;
	logic flash_erase_o, flash_write_o, load_valid_o, access_refused_o, core_stall_o;
	logic section_busy_o, ready_irq_o, int_block_o, ext_prog_block_o;
	logic verify_block_o, fuse_locked_o, boot_lock_locked_o;
	logic [7:0] bad_pat[3] = '{8'h07, 8'h1f, 8'h02};
	logic [7:0] late_pat[3] = '{8'h03, 8'h05, 8'h09};
	logic [7:0] ld_ctl[3] = '{8'h09, 8'h09, 8'h21};
	logic [7:0] ld_exp[3] = '{8'hef, FUSE_VAL, SIG_VAL};
	int n_errors = 0, checks_done = 0;

	always #25 clk_sys_i = ~clk_sys_i;

	spf_ctrl DUT (
		.clk_sys_i, .srst_i, .ce_i(1'b1),
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.store_instr_i, .load_instr_i, .zptr_i, .data_pair_i,
		.exec_boot_i, .vec_boot_i, .global_int_i, .fuse_byte_i, .sig_byte_i(SIG_VAL),
		.chip_erase_i, .ext_lock_wr_i, .ext_lock_data_i, .flash_done_i,
		.buf_rd_idx_i, .buf_rd_data_o, .flash_erase_o, .flash_write_o, .flash_page_o,
		.load_data_o, .load_valid_o, .access_refused_o, .core_stall_o, .section_busy_o,
		.ready_irq_o, .int_block_o, .ext_prog_block_o, .verify_block_o,
		.fuse_locked_o, .boot_lock_locked_o
	);

	spf_core_model u_core (
		.clk_i(clk_sys_i), .store_o(store_instr_i), .load_o(load_instr_i),
		.zptr_o(zptr_i), .data_o(data_pair_i)
	);

	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc

	// Ready-based; bready stays high, so the answer edge ends the transfer
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic b;
		b = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h0, d};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!b) begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o) b = 1'b1;
		end
		resp = {30'h0, s_axi_bresp_o};
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		logic t;
		t = 1'b0;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		while (!t) begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o) t = 1'b1;
		end
		resp = {30'h0, s_axi_rresp_o};
		chk(s_axi_rdata_o, exp);
	endtask : rchk

	task automatic bchk(input logic [6:0] idx, input logic [15:0] exp);
		buf_rd_idx_i <= idx;
		cyc(1);
		chk(buf_rd_data_o, exp);
	endtask : bchk

	task automatic fin;
		flash_done_i <= 1'b1;
		@(posedge clk_sys_i);
		flash_done_i <= 1'b0;
		cyc(1);
	endtask : fin

	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#500000;
		n_errors++;
		stop_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (8) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rchk(OFF_CTRL, 32'h0);
		rchk(OFF_LOCK, 32'hff);
		rchk(4'h8, 32'h0);
		chk(resp, {30'h0, RESP_SLVERR});
		wr(4'h8, 8'h81);
		chk(resp, {30'h0, RESP_SLVERR});
		wr(OFF_LOCK, 8'h00);
		chk(resp, {30'h0, RESP_OKAY});
		rchk(OFF_LOCK, 32'hff);
		foreach (bad_pat[i]) begin
			wr(OFF_CTRL, bad_pat[i]);
			rchk(OFF_CTRL, 32'h0);
		end
		wr(OFF_CTRL, {3'h0, PAT_FILL});
		u_core.op(1'b1, {10'h3, 7'h05, 1'b1}, 16'h1234);
		bchk(7'h05, 16'h1234);
		rchk(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, {3'h0, PAT_REEN});
		bchk(7'h05, 16'hffff);
		cyc(4);
		wr(OFF_CTRL, {3'h0, PAT_ERASE});
		u_core.op(1'b1, {10'h3, 8'h0}, 16'h0);
		chk({flash_erase_o, section_busy_o, core_stall_o}, 32'h6);
		chk(flash_page_o, 32'h3);
		rchk(OFF_CTRL, 32'h43);
		wr(OFF_CTRL, {3'h0, PAT_REEN});
		u_core.op(1'b1, 18'h0, 16'h0);
		chk(section_busy_o, 32'h1);
		fin();
		rchk(OFF_CTRL, 32'h40);
		wr(OFF_CTRL, {3'h0, PAT_REEN});
		u_core.op(1'b1, 18'h0, 16'h0);
		chk(section_busy_o, 32'h0);
		wr(OFF_CTRL, {3'h0, PAT_ERASE});
		u_core.op(1'b1, {10'h3, 8'h0}, 16'h0);
		fin();
		wr(OFF_CTRL, {3'h0, PAT_FILL});
		u_core.op(1'b1, 18'h0, 16'hbeef);
		chk(section_busy_o, 32'h0);
		wr(OFF_CTRL, {3'h0, PAT_WRITE});
		u_core.op(1'b1, {10'd992, 7'h1, 1'b0}, 16'h0);
		chk({access_refused_o, flash_write_o}, 32'h2);
		wr(OFF_CTRL, {3'h0, PAT_WRITE});
		u_core.op(1'b1, {10'd992, 8'h0}, 16'h0);
		chk({flash_write_o, core_stall_o, section_busy_o}, 32'h6);
		chk(flash_page_o, 32'd992);
		fin();
		chk(core_stall_o, 32'h0);
		foreach (late_pat[i]) begin
			wr(OFF_CTRL, late_pat[i]);
			// First edge after the fourth one, so the store just misses the window
			cyc(3);
			u_core.op(1'b1, {10'h3, 8'h0}, 16'hffff);
			chk({flash_erase_o, flash_write_o}, 32'h0);
			rchk(OFF_CTRL, 32'h0);
		end
		wr(OFF_CTRL, {3'h0, PAT_LOCK});
		// Store lands on the last edge of the window
		cyc(2);
		u_core.op(1'b1, 18'h3ffff, 16'h00ef);
		rchk(OFF_LOCK, 32'hef);
		wr(OFF_CTRL, {3'h0, PAT_LOCK});
		u_core.op(1'b1, 18'h0, 16'h00ff);
		rchk(OFF_LOCK, 32'hef);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_CTRL, ld_ctl[i]);
			cyc(i[0]);
			u_core.op(1'b0, {17'h0, i[0]}, 16'h0);
			chk({load_valid_o, load_data_o}, {23'h0, 1'b1, ld_exp[i]});
		end
		wr(OFF_CTRL, {3'h0, PAT_LOCK});
		u_core.op(1'b1, 18'h0, 16'h00f3);
		rchk(OFF_LOCK, 32'he3);
		for (int i = 0; i < 2; i++) begin
			wr(OFF_CTRL, {3'h0, PAT_ERASE});
			u_core.op(1'b1, {i[0] ? 10'd992 : 10'h3, 8'h0}, 16'h0);
			chk({access_refused_o, flash_erase_o}, 32'h2);
		end
		vec_boot_i <= 1'b1;
		cyc(1);
		chk(int_block_o, 32'h1);
		exec_boot_i <= 1'b1;
		u_core.op(1'b0, {10'h3, 8'h0}, 16'h0);
		chk(access_refused_o, 32'h1);
		exec_boot_i <= 1'b0;
		vec_boot_i <= 1'b0;
		chip_erase_i <= 1'b1;
		cyc(1);
		chip_erase_i <= 1'b0;
		rchk(OFF_LOCK, 32'hff);
		for (int i = 0; i < 2; i++) begin
			ext_lock_data_i <= i[0] ? 8'hfc : 8'hfe;
			ext_lock_wr_i <= 1'b1;
			cyc(1);
			ext_lock_wr_i <= 1'b0;
			cyc(1);
			chk({ext_prog_block_o, verify_block_o, fuse_locked_o, boot_lock_locked_o},
				i[0] ? 32'hf : 32'ha);
		end
		wr(OFF_CTRL, 8'h80);
		cyc(1);
		chk(ready_irq_o, 32'h1);
		global_int_i <= 1'b0;
		cyc(1);
		chk(ready_irq_o, 32'h0);
		global_int_i <= 1'b1;
		wr(OFF_CTRL, 8'h81);
		cyc(0);
		chk(ready_irq_o, 32'h0);
		stop_test();
	end
endmodule : tb
